// ===== src/mil_pkg.sv
// package: constants, state types and carriers of the interrupt logic
package mil_pkg;
	////////////////////////////////////////////////////////////////
	// timing: instruction cycle is four clock phases
	localparam int MIL_CLK_NS = 100;
	localparam int MIL_TCY_NS = 400;
	localparam int MIL_PHASES = MIL_TCY_NS / MIL_CLK_NS;
	// instruction cycles from recognition at phase one to the vector
	localparam logic [1:0] MIL_ENTRY_TCY = 2'h2;

	////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] MIL_OFS_CONTROL = 8'h00;
	localparam logic [7:0] MIL_OFS_OPTION = 8'h04;
	localparam logic [7:0] MIL_OFS_AUX = 8'h08;
	localparam logic [7:0] MIL_OFS_CORE = 8'h0c;
	localparam logic [7:0] MIL_OFS_NONE = 8'hff;
	localparam logic [2:0] MIL_HSIZE_WORD = 3'h2;

	// irq_control_reg fields
	localparam int MIL_BIT_PORT_FLAG = 0;
	localparam int MIL_BIT_EXT_FLAG = 1;
	localparam int MIL_BIT_TMR_FLAG = 2;
	localparam int MIL_BIT_PORT_EN = 3;
	localparam int MIL_BIT_EXT_EN = 4;
	localparam int MIL_BIT_TMR_EN = 5;
	localparam int MIL_BIT_GLOBAL_EN = 7;
	// option register and write-complete register fields
	localparam int MIL_BIT_EDGE = 6;
	localparam int MIL_BIT_WR_FLAG = 0;
	localparam int MIL_BIT_WR_EN = 1;

	// reset values and implemented bits
	localparam logic [7:0] MIL_CONTROL_RST = 8'h00;
	localparam logic [7:0] MIL_CONTROL_MASK = 8'hbf;
	localparam logic [7:0] MIL_OPTION_RST = 8'hff;
	localparam logic [12:0] MIL_VECTOR = 13'h0004;

	////////////////////////////////////////////////////////////////
	// enumerations
	typedef enum logic [1:0] {
		MIL_PH1 = 2'b00,
		MIL_PH2 = 2'b01,
		MIL_PH3 = 2'b10,
		MIL_PH4 = 2'b11
	} mil_phase_t;

	typedef enum logic [1:0] {
		MIL_RUN = 2'b00,
		MIL_ENTRY = 2'b01,
		MIL_SLEEP = 2'b10
	} mil_seq_t;

	////////////////////////////////////////////////////////////////
	// carriers to and from the processor core
	typedef struct packed {
		logic [12:0] pc;
		logic timer_wrap;
		logic wr_done;
		logic port_read;
		logic return_from_irq;
		logic sleep_req;
	} mil_core_in_t;

	typedef struct packed {
		logic irq_request;
		logic vector_load;
		logic [12:0] vector_addr;
		logic stack_push;
		logic [12:0] push_pc;
		logic wake;
		logic sleeping;
		logic [1:0] phase;
	} mil_core_out_t;

	// whole state of the interrupt logic
	typedef struct packed {
		logic [7:0] control;
		logic [7:0] option;
		logic wr_flag;
		logic wr_en;
		logic [3:0] port_ref;
		logic ext_pend;
		mil_phase_t phase;
		mil_seq_t seq;
		logic [1:0] entry_cnt;
		logic [2:0] wake_en;
		logic bus_wr;
		logic bus_rd;
		logic [7:0] bus_addr;
		logic hready_q;
		logic resp;
		logic [31:0] rdata;
		mil_core_out_t core;
	} mil_state_t;

	localparam mil_state_t MIL_STATE_RST = '{
		control: MIL_CONTROL_RST,
		option: MIL_OPTION_RST,
		phase: MIL_PH1,
		seq: MIL_RUN,
		hready_q: 1'h1,
		core: '{vector_addr: MIL_VECTOR, default: '0},
		default: '0
	};
endpackage : mil_pkg

// ===== src/mil_sync.sv
// two-flop synchroniser with a third stage for edge detection
`timescale 1ns/1ps
module mil_sync #(
	parameter int WIDTH = 1
) (
	// clock, reset and freeze
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// asynchronous input
	input wire logic [WIDTH-1:0] din,
	// synchronised level and its value one clock earlier
	output logic [WIDTH-1:0] q,
	output logic [WIDTH-1:0] q_prev
);
	import mil_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
		logic [WIDTH-1:0] prev;
	} mil_sync_state_t;

	mil_sync_state_t r;
	mil_sync_state_t next_r;

	////////////////////////////////////////////////////////////////
	// meta is read by the sync stage only, never by detection logic
	always_comb begin
		next_r.meta = din;
		next_r.sync = r.meta;
		next_r.prev = r.sync;
	end

	// state register, frozen while ce is low
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign q = r.sync;
	assign q_prev = r.prev;
endmodule : mil_sync

// ===== src/mil_irq_logic.sv
// interrupt logic of the core: sources, flags, enables, vectoring, ahb-lite registers
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module mil_irq_logic (
	// clock, reset and freeze
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// device pins
	input wire logic ext_irq_pin,
	input wire logic [3:0] upper_io_port,
	// processor core
	input wire mil_pkg::mil_core_in_t core_in,
	output mil_pkg::mil_core_out_t core_out
);
	import mil_pkg::*;

	mil_state_t r;
	mil_state_t next_r;
	logic ext_level;
	logic ext_prev;
	logic [3:0] port_level;
	logic ext_edge;
	logic port_change;
	logic port_miss;
	logic [3:0] pend;
	logic [2:0] wake_hit;
	logic accept;
	logic mapped;
	logic [31:0] rd_mux;

	////////////////////////////////////////////////////////////////
	// pin synchronisers
	mil_sync #(
		.WIDTH(1)
	) u_ext_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.din(ext_irq_pin),
		.q(ext_level),
		.q_prev(ext_prev)
	);

	mil_sync #(
		.WIDTH(4)
	) u_port_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.din(upper_io_port),
		.q(port_level),
		.q_prev()
	);

	////////////////////////////////////////////////////////////////
	// source detection and request terms
	always_comb begin
		if (r.option[MIL_BIT_EDGE]) begin
			ext_edge = ext_level & ~ext_prev;
		end else begin
			ext_edge = ~ext_level & ext_prev;
		end
		port_change = (port_level != r.port_ref);
		// read at phase two swallows the change
		port_miss = core_in.port_read && (r.phase == MIL_PH2);
		// four sources, each gated by its own enable
		pend[0] = r.control[MIL_BIT_PORT_FLAG] & r.control[MIL_BIT_PORT_EN];
		pend[1] = r.control[MIL_BIT_EXT_FLAG] & r.control[MIL_BIT_EXT_EN];
		pend[2] = r.control[MIL_BIT_TMR_FLAG] & r.control[MIL_BIT_TMR_EN];
		pend[3] = r.wr_flag & r.wr_en;
		// only enables caught at sleep entry may wake
		wake_hit = {r.wr_flag, r.control[MIL_BIT_EXT_FLAG], r.control[MIL_BIT_PORT_FLAG]}
			& r.wake_en;
		// recognition happens on phase one only
		accept = (r.seq == MIL_RUN) && (r.phase == MIL_PH1) && r.control[MIL_BIT_GLOBAL_EN]
			&& (|pend);
		mapped = (haddr[31:8] == 24'h0);
	end

	////////////////////////////////////////////////////////////////
	// read data for the register addressed in the pending read
	always_comb begin
		rd_mux = 32'h0;
		case (r.bus_addr)
			MIL_OFS_CONTROL: begin
				rd_mux[7:0] = r.control;
			end
			MIL_OFS_OPTION: begin
				rd_mux[7:0] = r.option;
			end
			// write-complete flag kept outside the control register
			MIL_OFS_AUX: begin
				rd_mux[MIL_BIT_WR_FLAG] = r.wr_flag;
				rd_mux[MIL_BIT_WR_EN] = r.wr_en;
			end
			MIL_OFS_CORE: begin
				rd_mux[7:0] = {2'h0, r.seq, r.core.irq_request, r.ext_pend, r.phase};
			end
			default: begin
				rd_mux = 32'h0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		next_r = r;
		next_r.core.vector_load = 1'h0;
		next_r.core.stack_push = 1'h0;
		next_r.core.wake = 1'h0;
		next_r.hready_q = 1'h1;
		next_r.resp = 1'h0;
		next_r.phase = mil_phase_t'(r.phase + 2'h1);

		// data phase of a write: hwdata is valid now
		if (r.bus_wr) begin
			if (r.bus_addr == MIL_OFS_CONTROL) begin
				next_r.control = hwdata[7:0] & MIL_CONTROL_MASK;
			end else if (r.bus_addr == MIL_OFS_OPTION) begin
				next_r.option = hwdata[7:0];
			end else if (r.bus_addr == MIL_OFS_AUX) begin
				next_r.wr_flag = hwdata[MIL_BIT_WR_FLAG];
				next_r.wr_en = hwdata[MIL_BIT_WR_EN];
			end
		end

		// read data sampled one clock late so a preceding write is visible
		if (r.bus_rd) begin
			next_r.rdata = rd_mux;
			next_r.bus_rd = 1'h0;
		end

		// address phase; only whole-word transfers act, others read as zero
		next_r.bus_wr = 1'h0;
		if (hsel && htrans[1] && hready) begin
			next_r.bus_addr = (mapped && hsize == MIL_HSIZE_WORD) ? haddr[7:0] : MIL_OFS_NONE;
			next_r.bus_wr = hwrite;
			next_r.bus_rd = !hwrite;
			next_r.hready_q = hwrite;
		end

		// a pin edge waits in ext_pend until phase four or one
		next_r.ext_pend = r.ext_pend | ext_edge;
		if (next_r.ext_pend && (r.phase == MIL_PH4 || r.phase == MIL_PH1)) begin
			// pin flag set, wins over a clearing write
			next_r.control[MIL_BIT_EXT_FLAG] = 1'h1;
			next_r.ext_pend = 1'h0;
		end
		// timer wrap, no peripheral clock while asleep
		if (core_in.timer_wrap && r.seq != MIL_SLEEP) begin
			next_r.control[MIL_BIT_TMR_FLAG] = 1'h1;
		end
		// port change flag, sticky until software clears
		if (port_change && !port_miss) begin
			next_r.control[MIL_BIT_PORT_FLAG] = 1'h1;
		end
		if (core_in.port_read) begin
			next_r.port_ref = port_level;
		end
		if (core_in.wr_done) begin
			next_r.wr_flag = 1'h1;
		end
		if (core_in.return_from_irq) begin
			next_r.control[MIL_BIT_GLOBAL_EN] = 1'h1;
		end
		next_r.core.irq_request = r.control[MIL_BIT_GLOBAL_EN] && (|pend);

		// entry and sleep sequencer
		unique case (r.seq)
			MIL_RUN: begin
				if (core_in.sleep_req && !(|pend)) begin
					// snapshot wake enables at sleep entry
					next_r.wake_en = {r.wr_en, r.control[MIL_BIT_EXT_EN], r.control[MIL_BIT_PORT_EN]};
					next_r.seq = MIL_SLEEP;
				end else if (accept) begin
					// accept clears after a same-cycle write, so it wins
					next_r.control[MIL_BIT_GLOBAL_EN] = 1'h0;
					next_r.entry_cnt = MIL_ENTRY_TCY;
					next_r.seq = MIL_ENTRY;
				end
			end
			MIL_ENTRY: begin
				// vector two instruction cycles after recognition
				if (r.phase == MIL_PH1) begin
					if (r.entry_cnt == 2'h1) begin
						// only the return address is pushed
						next_r.core.stack_push = 1'h1;
						next_r.core.push_pc = core_in.pc;
						next_r.core.vector_load = 1'h1;
						next_r.seq = MIL_RUN;
					end else begin
						next_r.entry_cnt = r.entry_cnt - 2'h1;
					end
				end
			end
			MIL_SLEEP: begin
				// wake always; vector only with global enable
				if (|wake_hit) begin
					next_r.core.wake = 1'h1;
					if (r.control[MIL_BIT_GLOBAL_EN]) begin
						next_r.control[MIL_BIT_GLOBAL_EN] = 1'h0;
						next_r.entry_cnt = MIL_ENTRY_TCY;
						next_r.seq = MIL_ENTRY;
					end else begin
						next_r.seq = MIL_RUN;
					end
				end
			end
			default: begin
				next_r.seq = MIL_RUN;
			end
		endcase
		next_r.core.sleeping = (next_r.seq == MIL_SLEEP);
		next_r.core.phase = next_r.phase;
	end

	////////////////////////////////////////////////////////////////
	// state register; ce low freezes bus and core sides alike
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= MIL_STATE_RST;
		end else if (ce) begin
			r <= next_r;
		end
	end

	// every output straight from the state register
	assign hreadyout = r.hready_q;
	assign hresp = r.resp;
	assign hrdata = r.rdata;
	assign core_out = r.core;

	////////////////////////////////////////////////////////////////
	// checks; a frozen cycle abandons any attempt in flight
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn || !ce);

	sequence s_accept;
		accept;
	endsequence

	sequence s_entry_wait;
		(!r.core.vector_load) [*8] ##1 r.core.vector_load;
	endsequence

	sequence s_ext_set;
		##[1:4] r.control[MIL_BIT_EXT_FLAG];
	endsequence

	a_accept_clears_enable:
	assert property (s_accept |=> !r.control[MIL_BIT_GLOBAL_EN] && r.seq == MIL_ENTRY)
		else $error("global enable still set after accept");

	a_entry_latency:
	assert property (s_accept |-> ##1 s_entry_wait)
		else $error("vector not loaded two instruction cycles after accept");

	a_vector_target:
	assert property (r.core.vector_load |-> r.core.stack_push
		&& r.core.vector_addr == MIL_VECTOR && r.seq == MIL_RUN)
		else $error("vector load without push or wrong address");

	a_return_enable:
	assert property (core_in.return_from_irq && !accept |=> r.control[MIL_BIT_GLOBAL_EN])
		else $error("return did not restore global enable");

	a_timer_flag_set:
	assert property (core_in.timer_wrap && r.seq != MIL_SLEEP
		|=> r.control[MIL_BIT_TMR_FLAG])
		else $error("timer wrap lost");

	a_ext_edge_flag:
	assert property (ext_edge |-> s_ext_set)
		else $error("pin edge did not set its flag within four clocks");

	a_port_change_flag:
	assert property (port_change && !port_miss |=> r.control[MIL_BIT_PORT_FLAG])
		else $error("port change did not set its flag");

	a_request_raise:
	assert property (r.control[MIL_BIT_GLOBAL_EN] && (|pend) |=> r.core.irq_request)
		else $error("request missing with enabled pending source");

	a_global_blocks:
	assert property (!r.control[MIL_BIT_GLOBAL_EN] |=> !r.core.irq_request)
		else $error("request raised while global enable clear");

	a_sleep_wake:
	assert property (r.seq == MIL_SLEEP && (|wake_hit)
		|=> r.core.wake && r.seq != MIL_SLEEP
		&& $past(r.control[MIL_BIT_GLOBAL_EN]) == (r.seq == MIL_ENTRY))
		else $error("wake from sleep wrong");
endmodule : mil_irq_logic

// ===== tb/mil_core_model.sv
// partner model: core sequencer that fetches, takes the vector and returns from service
`timescale 1ns/1ps
module mil_core_model (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// from the interrupt logic
	input wire logic [1:0] phase,
	input wire logic vector_load,
	input wire logic [12:0] vector_addr,
	// service length in instruction cycles, zero means the routine never returns
	input wire logic [7:0] svc_tcy,
	// to the interrupt logic
	output logic [12:0] pc,
	output logic return_from_irq
);
	logic [9:0] svc_cnt;
	logic in_svc;

	////////////////////////////////////////////////////////////////
	// fetch steps once per instruction cycle; the vector replaces the fetch address
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc <= 13'h0000;
			in_svc <= 1'b0;
			svc_cnt <= 10'h000;
			return_from_irq <= 1'b0;
		end else begin
			return_from_irq <= 1'b0;
			if (vector_load) begin
				pc <= vector_addr;
				in_svc <= (svc_tcy != 8'h00);
				svc_cnt <= {svc_tcy, 2'b00};
			end else begin
				if (phase == 2'h3) pc <= pc + 13'h0001;
				if (in_svc) svc_cnt <= svc_cnt - 10'h001;
				// a long service lets software clear its flags before the return
				if (in_svc && svc_cnt == 10'h001) begin
					in_svc <= 1'b0;
					return_from_irq <= 1'b1;
				end
			end
		end
	end
endmodule : mil_core_model

// ===== tb/mil_irq_logic_tb.sv
// self-checking bench of the interrupt logic with a core model on its far side
`timescale 1ns/1ps
module mil_irq_logic_tb;
	import mil_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ext_irq_pin, m_ret, vl;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [3:0] upper_io_port, pv;
	logic [7:0] svc_tcy, d;
	logic [12:0] m_pc, p;
	mil_core_in_t core_in;
	mil_core_out_t core_out;
	int failures, total_checks, seed, n, i;

	// pulse lines: timer wrap, write done, port read, sleep request
	assign core_in = {m_pc, pv[3], pv[2], pv[1], m_ret, pv[0]};

	mil_irq_logic mil_irq_logic_inst (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.ext_irq_pin, .upper_io_port, .core_in, .core_out);
	mil_core_model mil_core_model_inst (.hclk, .hresetn, .phase(core_out.phase),
		.vector_load(core_out.vector_load), .vector_addr(core_out.vector_addr),
		.svc_tcy, .pc(m_pc), .return_from_irq(m_ret));

	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	////////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : stop_test

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// one ahb-lite single transfer; the address phase is held until hready is seen high
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
		int k, c;
		@(posedge hclk);
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= w;
		for (k = 0; k < 2; k++) begin
			c = 0;
			do begin
				@(posedge hclk);
				c++;
			end while (hreadyout !== 1'b1 && c < 40);
			if (c >= 40) begin
				failures++;
				stop_test();
			end
			htrans <= 2'b00;
			hwdata <= {24'h000000, wd};
		end
		rd = hrdata;
	endtask : bus

	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 8'h00);
		check(what, exp, rd);
		check("response", 32'h0, {31'h0, hresp});
	endtask : rdchk

	task automatic clk(input int c);
		repeat (c) @(posedge hclk);
	endtask : clk

	task automatic pulse(input int w);
		@(posedge hclk);
		pv <= 4'h1 << w;
		@(posedge hclk);
		pv <= 4'h0;
	endtask : pulse

	task automatic pin(input logic v);
		@(posedge hclk);
		ext_irq_pin <= v;
	endtask : pin

	// bounded wait for vector, return or wake; keeps the core pc of the cycle before
	task automatic await(input int w);
		n = 0;
		do begin
			p = m_pc;
			@(posedge hclk);
			n++;
		end while ((w == 0 ? core_out.vector_load : w == 1 ? m_ret : core_out.wake) !== 1'b1
			&& n < 400);
		if (n >= 400) begin
			failures++;
			stop_test();
		end
	endtask : await

	// control readback: bit 6 is not implemented
	function automatic logic [31:0] ctrl_exp(input logic [7:0] v);
		return {24'h000000, v & MIL_CONTROL_MASK};
	endfunction : ctrl_exp

	////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'ha933f326;
		hresetn = 1'b0;
		hsel = 1'b1;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = MIL_HSIZE_WORD;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		ext_irq_pin = 1'b0;
		upper_io_port = 4'h0;
		pv = 4'h0;
		svc_tcy = 8'h3c;
		clk(12);
		hresetn <= 1'b1;
		rdchk("control reset", MIL_OFS_CONTROL, 32'h00);
		rdchk("option reset", MIL_OFS_OPTION, 32'hff);
		rdchk("unmapped", 8'h40, 32'h00);
		// timer wrap with every enable off still raises its flag
		pulse(3);
		clk(2);
		rdchk("timer flag", MIL_OFS_CONTROL, 32'h04);
		check("timer quiet", 0, core_out.irq_request);
		$display("done reset and timer");
		// falling then rising selection; the other edge must leave the flag clear
		for (i = 0; i < 2; i++) begin
			bus(1'b1, MIL_OFS_OPTION, i ? 8'hff : 8'hbf);
			// park the pin so the wrong edge really toggles it
			pin(i[0]);
			clk(10);
			bus(1'b1, MIL_OFS_CONTROL, 8'h00);
			pin(~i[0]);
			clk(10);
			rdchk("wrong edge", MIL_OFS_CONTROL, 32'h00);
			pin(i[0]);
			clk(10);
			rdchk("valid edge", MIL_OFS_CONTROL, 32'h02);
		end
		// port change against the value of the last port read
		pulse(1);
		bus(1'b1, MIL_OFS_CONTROL, 8'h00);
		@(posedge hclk);
		upper_io_port <= 4'(({$random(seed)} % 15) + 1);
		clk(10);
		rdchk("port flag", MIL_OFS_CONTROL, 32'h01);
		pulse(1);
		bus(1'b1, MIL_OFS_CONTROL, 8'h00);
		clk(10);
		rdchk("port settled", MIL_OFS_CONTROL, 32'h00);
		$display("done edges and port");
		// full entry from a rising pin edge with the global enable set
		pin(1'b0);
		clk(10);
		bus(1'b1, MIL_OFS_CONTROL, 8'h90);
		pin(1'b1);
		await(0);
		check("latency", 1, n >= 3 * MIL_PHASES && n <= 4 * MIL_PHASES + 2);
		check("vector", MIL_VECTOR, core_out.vector_addr);
		check("push", 1, core_out.stack_push);
		check("return pc", p, core_out.push_pc);
		rdchk("entry", MIL_OFS_CONTROL, 32'h12);
		// service clears its flag before the return
		bus(1'b1, MIL_OFS_CONTROL, 8'h10);
		await(1);
		clk(2);
		rdchk("return", MIL_OFS_CONTROL, 32'h90);
		$display("done entry and return");
		// global enable off, then source enable off
		bus(1'b1, MIL_OFS_CONTROL, 8'h10);
		pin(1'b0);
		clk(4);
		pin(1'b1);
		clk(30);
		check("global blocks", 0, core_out.irq_request);
		rdchk("flag kept", MIL_OFS_CONTROL, 32'h12);
		bus(1'b1, MIL_OFS_CONTROL, 8'h82);
		clk(30);
		check("masked", 0, core_out.irq_request);
		// clear the enable and read back until it shows clear
		i = 0;
		do begin
			bus(1'b1, MIL_OFS_CONTROL, 8'h02);
			bus(1'b0, MIL_OFS_CONTROL, 8'h00);
			i++;
		end while (rd[7] !== 1'b0 && i < 4);
		check("disabled", 0, rd[7]);
		// sleep with the pin enabled and the global enable off
		bus(1'b1, MIL_OFS_CONTROL, 8'h10);
		pin(1'b0);
		clk(10);
		pulse(0);
		clk(2);
		check("sleeping", 1, core_out.sleeping);
		pin(1'b1);
		await(2);
		vl = 1'b0;
		repeat (20) begin
			@(posedge hclk);
			vl = vl | core_out.vector_load;
		end
		check("in line", 0, vl);
		check("awake", 0, core_out.sleeping);
		pulse(2);
		clk(2);
		rdchk("write flag", MIL_OFS_AUX, 32'h01);
		rdchk("control keeps", MIL_OFS_CONTROL, 32'h12);
		$display("done masking and sleep");
		// random register traffic with the global enable kept off
		for (i = 0; i < 8; i++) begin
			d = 8'($random(seed));
			bus(1'b1, MIL_OFS_OPTION, d);
			rdchk("option", MIL_OFS_OPTION, {24'h000000, d});
			bus(1'b1, MIL_OFS_CONTROL, d & 8'h7f);
			rdchk("control", MIL_OFS_CONTROL, ctrl_exp(d & 8'h7f));
		end
		$display("done random traffic");
		stop_test();
	end
endmodule : mil_irq_logic_tb
